// file: rtl/sema_gate_pkg.sv
// constants, field positions and types shared by the semaphore gate bank
// assumes a 32-bit APB4 slave with byte strobes and an 8-bit byte address
package sema_gate_pkg;

  localparam int unsigned GATE_COUNT      = 64;
  localparam int unsigned ADDR_W          = 8;

  // byte addresses and the reset-gate word index
  localparam logic [7:0]  GATE_BASE_ADDR  = 8'h00;
  localparam logic [7:0]  RESET_LOC_ADDR  = 8'h40;
  localparam logic [5:0]  RESET_LOC_WORD  = 6'h10;

  // gate register fields
  localparam int unsigned LOCK_STATE_LSB  = 0;
  localparam int unsigned DOMAIN_LSB      = 4;
  localparam logic [3:0]  FREE_CODE       = 4'h0;
  localparam logic [3:0]  MASTER_MAX      = 4'hF;
  localparam logic [1:0]  DOMAIN_RESET    = 2'h0;

  // reset-gate location fields
  localparam int unsigned PATTERN_LSB     = 0;
  localparam int unsigned SEQ_STATE_LSB   = 4;
  localparam int unsigned SELECTOR_LSB    = 8;
  localparam logic [7:0]  ARM_PATTERN     = 8'hE2;
  localparam logic [7:0]  FIRE_PATTERN    = 8'h1D;
  localparam logic [7:0]  SELECTOR_RESET  = 8'h00;
  localparam logic [3:0]  MASTER_RESET    = 4'h0;
  localparam logic [7:0]  GATE_LIMIT      = 8'h40;
  localparam logic [3:0]  HALF_WORD_STRB  = 4'h3;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_CLEAR
  } seq_state_e;

endpackage

// file: rtl/gate_clear_sequencer.sv
// two-write secure clear sequencer for the semaphore gate bank
// assumes wr_valid is a one-cycle pulse per committed 16-bit write
`timescale 1ns/100ps
`default_nettype none
module gate_clear_sequencer (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // committed write to the reset-gate location
  input  wire logic                    wr_valid,
  input  wire logic [15:0]             wr_data,
  input  wire logic [3:0]              wr_master,
  // state seen by the gate bank and the read path
  output sema_gate_pkg::seq_state_e    clear_sequence_state,
  output logic      [3:0]              clear_requesting_master,
  output logic      [7:0]              clear_gate_selector
);
  import sema_gate_pkg::*;

  seq_state_e  next_state;
  logic [3:0]  next_master;
  logic [7:0]  next_selector;
  logic [7:0]  clear_pattern_byte;

  assign clear_pattern_byte = wr_data[PATTERN_LSB +: 8];

  always_comb begin
    next_state    = clear_sequence_state;
    next_master   = clear_requesting_master;
    next_selector = clear_gate_selector;
    if (wr_valid) begin
      next_master = wr_master;
    end
    case (clear_sequence_state)
      SEQ_IDLE: begin
        if (wr_valid && clear_pattern_byte == ARM_PATTERN) begin
          next_state = SEQ_ARMED;
        end
      end
      SEQ_ARMED: begin
        if (wr_valid) begin
          // mismatch just drops back, no error raised
          if (clear_pattern_byte == FIRE_PATTERN && wr_master == clear_requesting_master) begin
            next_state    = SEQ_CLEAR;
            next_selector = wr_data[SELECTOR_LSB +: 8];
          end else begin
            next_state = SEQ_IDLE;
          end
        end
      end
      SEQ_CLEAR: next_state = SEQ_IDLE;
      default:   next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_sequence_state    <= SEQ_IDLE;
      clear_requesting_master <= MASTER_RESET;
      clear_gate_selector     <= SELECTOR_RESET;
    end else begin
      clear_sequence_state    <= next_state;
      clear_requesting_master <= next_master;
      clear_gate_selector     <= next_selector;
    end
  end

endmodule // gate_clear_sequencer
`default_nettype wire

// file: rtl/sema_gate_bank.sv
// bank of 64 hardware semaphore gates with a secure two-write clear
// assumes an APB4 master; master identity arrives beside the bus
//
// How it works
// - each gate keeps a 4-bit lock state in the low nibble of its byte
// - only processor masters change gates; checked with master index and data
// - a locked gate is freed only by its owner or the secure clear; software must release
// - data neither free code nor own lock code is a no-op
// - reads may span gates; multi-byte gate writes give pslverr, no change
// - state 0 is free, k+1 is locked by master index k
// - bits 5:4 show locking domain; 00 is domain 0 only when locked
// - bits 7:6 of gate and reset-gate registers read zero
// - wrong pattern or other master silently abandons the sequence
// - selector below 64 clears that gate, otherwise all gates
// - selector comes from the second write and reads back as last cleared
// - reset-gate reads show state, master, selector and change nothing
// - sequencer codes: 00 idle, 01 armed, 10 clear for one cycle
// - writing master is recorded on every processor half-word reset-gate write; must match
// - the pattern byte is write-only and only matched
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module sema_gate_bank (
  // clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [sema_gate_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // identity of the master issuing the current transfer
  input  wire logic [3:0]                        master_index,
  input  wire logic [1:0]                        master_domain,
  input  wire logic                              master_is_processor
);
  import sema_gate_pkg::*;

  function automatic logic [3:0] lock_code(input logic [3:0] idx);
    lock_code = idx + 4'h1;
  endfunction

  function automatic logic [7:0] gate_byte(input logic [1:0] dom, input logic [3:0] st);
    gate_byte = {2'b00, dom, st};
  endfunction

  logic [3:0]  gate_lock_state [GATE_COUNT];
  logic [1:0]  locking_domain  [GATE_COUNT];
  logic [3:0]  next_lock_state [GATE_COUNT];
  logic [1:0]  next_domain     [GATE_COUNT];
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [255:0] gates_flat;

  seq_state_e  clear_sequence_state;
  logic [3:0]  clear_requesting_master;
  logic [7:0]  clear_gate_selector;

  // decode
  logic        access;
  logic        commit;
  logic        is_gate_word;
  logic        is_reset_word;
  logic        unmapped;
  logic [2:0]  strb_count;
  logic        gate_multi;
  logic [5:0]  wr_idx;
  logic [7:0]  wr_byte;
  logic        gate_commit;
  logic        reset_commit;

  assign access        = psel && penable && !pready;
  assign commit        = psel && penable && pready;
  assign is_gate_word  = paddr < RESET_LOC_ADDR;
  assign is_reset_word = paddr[7:2] == RESET_LOC_WORD;
  assign unmapped      = !is_gate_word && !is_reset_word;
  assign strb_count    = 3'(pstrb[0]) + 3'(pstrb[1]) + 3'(pstrb[2]) + 3'(pstrb[3]);
  assign gate_multi    = pwrite && is_gate_word && strb_count > 3'd1;

  always_comb begin
    wr_idx  = {paddr[5:2], 2'b00};
    wr_byte = pwdata[7:0];
    for (int b = 0; b < 4; b++) begin
      if (pstrb[b]) begin
        wr_idx  = {paddr[5:2], 2'(b)};
        wr_byte = pwdata[8*b +: 8];
      end
    end
  end

  // only processors move gates or drive the clear sequence
  assign gate_commit  = commit && pwrite && is_gate_word && strb_count == 3'd1 && master_is_processor;
  assign reset_commit = commit && pwrite && is_reset_word && pstrb == HALF_WORD_STRB && master_is_processor;

  gate_clear_sequencer u_clear_seq (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .wr_valid                (reset_commit),
    .wr_data                 (pwdata[15:0]),
    .wr_master               (master_index),
    .clear_sequence_state    (clear_sequence_state),
    .clear_requesting_master (clear_requesting_master),
    .clear_gate_selector     (clear_gate_selector)
  );

  // gate state
  always_comb begin
    for (int i = 0; i < GATE_COUNT; i++) begin
      next_lock_state[i] = gate_lock_state[i];
      next_domain[i]     = locking_domain[i];
    end
    if (gate_commit) begin
      if (wr_byte == {4'h0, FREE_CODE} && gate_lock_state[wr_idx] == lock_code(master_index)) begin
        next_lock_state[wr_idx] = FREE_CODE;
        next_domain[wr_idx]     = DOMAIN_RESET;
      end else if (wr_byte == {4'h0, lock_code(master_index)} && master_index != MASTER_MAX
                   && gate_lock_state[wr_idx] == FREE_CODE) begin
        next_lock_state[wr_idx] = lock_code(master_index);
        next_domain[wr_idx]     = master_domain;
      end
      // anything else is a no-op
    end
    if (clear_sequence_state == SEQ_CLEAR) begin
      for (int i = 0; i < GATE_COUNT; i++) begin
        if (clear_gate_selector >= GATE_LIMIT || clear_gate_selector == 8'(i)) begin
          next_lock_state[i] = FREE_CODE;
          next_domain[i]     = DOMAIN_RESET;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < GATE_COUNT; i++) begin
        gate_lock_state[i] <= FREE_CODE;
        locking_domain[i]  <= DOMAIN_RESET;
      end
    end else begin
      for (int i = 0; i < GATE_COUNT; i++) begin
        gate_lock_state[i] <= next_lock_state[i];
        locking_domain[i]  <= next_domain[i];
      end
    end
  end

  // apb answer: one wait state, data and error registered on the same edge that pready rises
  always_comb begin
    next_pready  = access;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (access) begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = unmapped || gate_multi;
      if (!pwrite && is_gate_word) begin
        for (int b = 0; b < 4; b++) begin
          next_prdata[8*b +: 8] = gate_byte(locking_domain[{paddr[5:2], 2'(b)}],
                                            gate_lock_state[{paddr[5:2], 2'(b)}]);
        end
      end else if (!pwrite && is_reset_word) begin
        // pattern byte never reads back
        next_prdata[SELECTOR_LSB +: 8]  = clear_gate_selector;
        next_prdata[SEQ_STATE_LSB +: 2] = clear_sequence_state;
        next_prdata[3:0]                = clear_requesting_master;
      end
    end else if (commit) begin
      next_pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // flattened view for checks
  always_comb begin
    gates_flat = '0;
    for (int i = 0; i < GATE_COUNT; i++) begin
      gates_flat[4*i +: 4] = gate_lock_state[i];
    end
  end

  logic dom_ok;
  always_comb begin
    dom_ok = 1'b1;
    for (int i = 0; i < GATE_COUNT; i++) begin
      if (gate_lock_state[i] == FREE_CODE && locking_domain[i] != DOMAIN_RESET) begin
        dom_ok = 1'b0;
      end
    end
  end

  // selector as a gate index, for the single-gate clear check
  logic [5:0] sel_idx;
  assign sel_idx = clear_gate_selector[5:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_multi_write_error: assert property (
    commit && gate_multi |-> pslverr ##1 $stable(gates_flat))
    else $error("multi-byte gate write not refused");

  chk_lock_free_gate: assert property (
    gate_commit && master_index != MASTER_MAX && gate_lock_state[wr_idx] == FREE_CODE
    && wr_byte == {4'h0, lock_code(master_index)} && clear_sequence_state != SEQ_CLEAR
    |=> gate_lock_state[$past(wr_idx)] == lock_code($past(master_index)))
    else $error("lock write did not lock free gate");

  chk_unlock_owner_only: assert property (
    gate_commit && wr_byte == 8'h00 && gate_lock_state[wr_idx] != lock_code(master_index)
    && clear_sequence_state != SEQ_CLEAR |=> $stable(gates_flat))
    else $error("gate freed by non-owner");

  chk_bad_data_nop: assert property (
    gate_commit && wr_byte != 8'h00 && wr_byte != {4'h0, lock_code(master_index)}
    && clear_sequence_state != SEQ_CLEAR |=> $stable(gates_flat))
    else $error("invalid gate data changed state");

  chk_clear_one_cycle: assert property (
    clear_sequence_state == SEQ_CLEAR |=> clear_sequence_state == SEQ_IDLE)
    else $error("clear state held more than one cycle");

  chk_clear_all_gates: assert property (
    clear_sequence_state == SEQ_CLEAR && clear_gate_selector >= GATE_LIMIT |=> gates_flat == '0)
    else $error("clear-all left a gate locked");

  chk_read_no_effect: assert property (
    commit && !pwrite && clear_sequence_state != SEQ_CLEAR |=> $stable(clear_sequence_state))
    else $error("read disturbed clear sequence");

  chk_abandon_silent: assert property (
    reset_commit && clear_sequence_state == SEQ_ARMED
    && (pwdata[7:0] != FIRE_PATTERN || master_index != clear_requesting_master)
    |-> !pslverr ##1 clear_sequence_state == SEQ_IDLE)
    else $error("bad second write not abandoned silently");

  chk_master_recorded: assert property (
    reset_commit |=> clear_requesting_master == $past(master_index))
    else $error("reset-gate writer not recorded");

  chk_free_domain_zero: assert property (dom_ok)
    else $error("free gate shows a domain");

  chk_reserved_zero: assert property (
    commit && !pwrite && is_reset_word |-> prdata[31:16] == 16'h0000 && prdata[7:6] == 2'b00)
    else $error("reserved reset-gate bits not zero");

  chk_owner_unlock_frees: assert property (
    gate_commit && wr_byte == 8'h00 && gate_lock_state[wr_idx] == lock_code(master_index)
    |=> gate_lock_state[$past(wr_idx)] == FREE_CODE)
    else $error("owner unlock did not free gate");

  chk_non_processor_ignored: assert property (
    commit && pwrite && is_gate_word && !master_is_processor && clear_sequence_state != SEQ_CLEAR
    |=> $stable(gates_flat))
    else $error("non-processor write changed a gate");

  chk_clear_single_gate: assert property (
    clear_sequence_state == SEQ_CLEAR && clear_gate_selector < GATE_LIMIT
    |=> gate_lock_state[$past(sel_idx)] == FREE_CODE)
    else $error("selected gate not cleared");

  chk_fire_starts_clear: assert property (
    reset_commit && clear_sequence_state == SEQ_ARMED && pwdata[7:0] == FIRE_PATTERN
    && master_index == clear_requesting_master |=> clear_sequence_state == SEQ_CLEAR)
    else $error("valid second write did not start clear");

  chk_arm_from_idle: assert property (
    reset_commit && clear_sequence_state == SEQ_IDLE && pwdata[7:0] == ARM_PATTERN
    |=> clear_sequence_state == SEQ_ARMED)
    else $error("first pattern did not arm sequence");

  chk_seq_code_unused: assert property (2'(clear_sequence_state) != 2'b11)
    else $error("sequencer in unused code");

  chk_gate_reserved_zero: assert property (
    commit && !pwrite && is_gate_word |-> prdata[7:6] == 2'b00 && prdata[15:14] == 2'b00
    && prdata[23:22] == 2'b00 && prdata[31:30] == 2'b00)
    else $error("reserved gate bits not zero");

  cov_gate_lock:  cover property (gate_commit ##1 gates_flat != $past(gates_flat));
  cov_clear_one:  cover property (clear_sequence_state == SEQ_CLEAR && clear_gate_selector < GATE_LIMIT);
  cov_clear_all:  cover property (clear_sequence_state == SEQ_CLEAR && clear_gate_selector >= GATE_LIMIT);
  cov_multi_err:  cover property (commit && gate_multi);
  cov_abandon:    cover property (reset_commit && clear_sequence_state == SEQ_ARMED
                                  && master_index != clear_requesting_master);

endmodule // sema_gate_bank
`default_nettype wire

// file: tb/proc_master_model.sv
// processor bus master model driving the apb side of the gate bank
// assumes one clock; identity lines travel with each request
`timescale 1ns/100ps
`default_nettype none
module proc_master_model (
  // clock
  input  wire logic        pclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  output logic [3:0]       master_index,
  output logic [1:0]       master_domain,
  output logic             master_is_processor,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, pstrb, master_is_processor} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    master_index = 4'h0;
    master_domain = 2'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb,
                      input logic [3:0] idx, input logic [1:0] dom, input logic proc,
                      output logic [31:0] rdata, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    master_index <= idx;
    master_domain <= dom;
    master_is_processor <= proc;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released pwdata, paddr and master_index carry inverted values; pstrb, pwrite and the other identity lines keep the last value
    pwdata <= ~data;
    paddr <= ~addr;
    master_index <= ~idx;
  endtask
endmodule // proc_master_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the semaphore gate bank
// assumes the master model file and the design files are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sema_gate_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, master_is_processor;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, master_index;
  logic [1:0]  master_domain;
  logic        rerr;
  logic [7:0]  exp_gate [64];
  int          miscompares = 0;
  int          total_checks = 0;

  sema_gate_bank i_sema_gate_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_index(master_index), .master_domain(master_domain),
    .master_is_processor(master_is_processor));
  proc_master_model i_proc_master_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .master_index(master_index),
    .master_domain(master_domain), .master_is_processor(master_is_processor), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [3:0] idx,
                    input logic proc);
    i_proc_master_model.xfer(1'b1, a, d, s, idx, 2'(idx), proc, rdat, rerr);
  endtask

  task automatic rd(input logic [7:0] a);
    i_proc_master_model.xfer(1'b0, a, 32'h0, 4'h0, 4'h0, 2'h0, 1'b1, rdat, rerr);
  endtask

  // byte write to one gate; domain follows the master index
  task automatic gw(input int g, input logic [7:0] v, input logic [3:0] idx, input logic proc);
    bw(8'(g & 60), 32'(v) << (8 * (g % 4)), 4'h1 << (g % 4), idx, proc);
  endtask

  task automatic check_gates;
    for (int w = 0; w < 16; w++) begin
      rd(8'(w * 4));
      chk("gate word", {exp_gate[w*4+3], exp_gate[w*4+2], exp_gate[w*4+1], exp_gate[w*4]}, rdat);
    end
  endtask

  task automatic t_lock;
    for (int k = 0; k < 15; k++) begin
      gw(k, 8'(k + 1), 4'(k), 1'b1);
      exp_gate[k] = {2'b00, 2'(k), 4'(k + 1)};
    end
    check_gates;
    gw(5, 8'h00, 4'd3, 1'b1);
    gw(5, 8'h04, 4'd3, 1'b1);
    gw(5, 8'h07, 4'd5, 1'b1);
    gw(5, 8'h00, 4'd5, 1'b0);
    gw(20, 8'h03, 4'd1, 1'b1);
    check_gates;
    gw(5, 8'h00, 4'd5, 1'b1);
    gw(5, 8'h02, 4'd1, 1'b1);
    exp_gate[5] = 8'h12;
    check_gates;
    $display("test lock done");
  endtask

  task automatic t_errors;
    bw(8'h10, 32'h0000_0202, 4'h3, 4'd1, 1'b1);
    chk("multi gate write error", 32'h1, 32'(rerr));
    rd(8'h44);
    chk("unmapped read error", 32'h1, 32'(rerr));
    rd(8'h04);
    chk("multi gate read error", 32'h0, 32'(rerr));
    check_gates;
    $display("test errors done");
  endtask

  task automatic t_clear;
    bw(RESET_LOC_ADDR, 32'h0000_AAE2, 4'h3, 4'd1, 1'b1);
    rd(RESET_LOC_ADDR);
    chk("armed status", 32'h0000_0011, rdat);
    rd(RESET_LOC_ADDR);
    chk("status after read", 32'h0000_0011, rdat);
    bw(RESET_LOC_ADDR, 32'h0000_071D, 4'h3, 4'd1, 1'b1);
    chk("clear error", 32'h0, 32'(rerr));
    exp_gate[7] = 8'h00;
    rd(RESET_LOC_ADDR);
    chk("cleared status", 32'h0000_0701, rdat);
    check_gates;
    $display("test clear done");
  endtask

  task automatic t_abort;
    bw(RESET_LOC_ADDR, 32'h0000_00E2, 4'h3, 4'd1, 1'b1);
    bw(RESET_LOC_ADDR, 32'h0000_031D, 4'h3, 4'd4, 1'b1);
    chk("abort error", 32'h0, 32'(rerr));
    rd(RESET_LOC_ADDR);
    chk("other master status", 32'h0000_0704, rdat);
    bw(RESET_LOC_ADDR, 32'h0000_00E2, 4'h3, 4'd1, 1'b1);
    bw(RESET_LOC_ADDR, 32'h0000_0355, 4'h3, 4'd1, 1'b1);
    rd(RESET_LOC_ADDR);
    chk("bad pattern status", 32'h0000_0701, rdat);
    check_gates;
    bw(RESET_LOC_ADDR, 32'h0000_00E2, 4'h3, 4'd2, 1'b1);
    bw(RESET_LOC_ADDR, 32'h0000_401D, 4'h3, 4'd2, 1'b1);
    foreach (exp_gate[i]) exp_gate[i] = 8'h00;
    rd(RESET_LOC_ADDR);
    chk("clear all status", 32'h0000_4002, rdat);
    check_gates;
    $display("test abort done");
  endtask

  // reset in mid-run with a gate locked and the sequencer armed
  task automatic t_midrun_reset;
    gw(9, 8'h04, 4'd3, 1'b1);
    bw(RESET_LOC_ADDR, 32'h0000_00E2, 4'h3, 4'd3, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (exp_gate[i]) exp_gate[i] = 8'h00;
    check_gates;
    rd(RESET_LOC_ADDR);
    chk("status after mid-run reset", 32'h0, rdat);
    $display("test mid-run reset done");
  endtask

  initial begin
    foreach (exp_gate[i]) exp_gate[i] = 8'h00;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_gates;
    rd(RESET_LOC_ADDR);
    chk("status reset", 32'h0, rdat);
    $display("test reset done");
    t_lock;
    t_errors;
    t_clear;
    t_abort;
    t_midrun_reset;
    close_out;
  end

  // whole run is under two hundred transfers of about four cycles
  initial begin
    repeat (10000) @(posedge pclk);
    miscompares++;
    close_out;
  end
endmodule // tb
`default_nettype wire
